// ---- tbsq_tap.v ----
// Test access port controller with bypass and user data register
`timescale 1ns/1ps
`include "tbsq_defines.vh"
// How it works
// - Update-IR loads instruction on falling TCK
// - Bypass captures 0 leaving Capture-DR
// - Output enabled on falling edge entering Shift-DR
// - Bypass is one stage; 101 in gives 010
// - Exit1-DR releases output on falling edge
// - Update-DR loads holding stage on falling edge, except when bypass is selected
// - Capture-IR loads 10000001
module tbsq_tap #(
   parameter DR_W = 8
) (
   // Clock and reset
   input  wire            REF_CLK,
   input  wire            RST,
   // Test pins
   input  wire            TCK,
   input  wire            TMS,
   input  wire            TDI,
   output wire            TDO_O,
   output wire            TDO_OE,
   // Parallel side
   output wire [7:0]      IR_ACTIVE,
   output wire [DR_W-1:0] DR_HOLD,
   output wire            IN_RESET
);

// ----------------------------------------
// Helper functions
// ----------------------------------------
// Matches the one-hot state word against one state code
function in_state;
   input [15:0] cur;
   input [15:0] code;
   begin
      in_state = (cur == code);
   end
endfunction

// Controller state after one rising test clock edge
function [15:0] next_state;
   input [15:0] cur;
   input        ms;
   begin
      case (cur)
         `TBSQ_ST_RESET:
            next_state = ms ? `TBSQ_ST_RESET : `TBSQ_ST_IDLE;
         `TBSQ_ST_IDLE:
            next_state = ms ? `TBSQ_ST_SELDR : `TBSQ_ST_IDLE;
         `TBSQ_ST_SELDR:
            next_state = ms ? `TBSQ_ST_SELIR : `TBSQ_ST_CAPDR;
         `TBSQ_ST_CAPDR:
            next_state = ms ? `TBSQ_ST_EX1DR : `TBSQ_ST_SHDR;
         `TBSQ_ST_SHDR:
            next_state = ms ? `TBSQ_ST_EX1DR : `TBSQ_ST_SHDR;
         `TBSQ_ST_EX1DR:
            next_state = ms ? `TBSQ_ST_UPDDR : `TBSQ_ST_PAUSDR;
         `TBSQ_ST_PAUSDR:
            next_state = ms ? `TBSQ_ST_EX2DR : `TBSQ_ST_PAUSDR;
         `TBSQ_ST_EX2DR:
            next_state = ms ? `TBSQ_ST_UPDDR : `TBSQ_ST_SHDR;
         `TBSQ_ST_UPDDR:
            next_state = ms ? `TBSQ_ST_SELDR : `TBSQ_ST_IDLE;
         `TBSQ_ST_SELIR:
            next_state = ms ? `TBSQ_ST_RESET : `TBSQ_ST_CAPIR;
         `TBSQ_ST_CAPIR:
            next_state = ms ? `TBSQ_ST_EX1IR : `TBSQ_ST_SHIR;
         `TBSQ_ST_SHIR:
            next_state = ms ? `TBSQ_ST_EX1IR : `TBSQ_ST_SHIR;
         `TBSQ_ST_EX1IR:
            next_state = ms ? `TBSQ_ST_UPDIR : `TBSQ_ST_PAUSIR;
         `TBSQ_ST_PAUSIR:
            next_state = ms ? `TBSQ_ST_EX2IR : `TBSQ_ST_PAUSIR;
         `TBSQ_ST_EX2IR:
            next_state = ms ? `TBSQ_ST_UPDIR : `TBSQ_ST_SHIR;
         `TBSQ_ST_UPDIR:
            next_state = ms ? `TBSQ_ST_SELDR : `TBSQ_ST_IDLE;
         default:
            next_state = `TBSQ_ST_RESET;
      endcase
   end
endfunction

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [1:0] tck_s_r;
reg [1:0] tms_s_r;
reg [1:0] tdi_s_r;
reg       tck_d_r;

// Test clock and mode select idle high; starting the stages high
// keeps a false rising edge from following reset
always @(posedge REF_CLK or posedge RST) begin
   if (RST) begin
      tck_s_r <= 2'h3;
      tms_s_r <= 2'h3;
      tdi_s_r <= 2'h0;
      tck_d_r <= 1'h1;
   end else begin
      tck_s_r <= {tck_s_r[0], TCK};
      tms_s_r <= {tms_s_r[0], TMS};
      tdi_s_r <= {tdi_s_r[0], TDI};
      tck_d_r <= tck_s_r[1];
   end
end

wire tck_rise = tck_s_r[1] & ~tck_d_r;
wire tck_fall = ~tck_s_r[1] & tck_d_r;
wire tms      = tms_s_r[1];
wire tdi      = tdi_s_r[1];

// ----------------------------------------
// State and shift registers
// ----------------------------------------
reg [15:0]     state_r;
reg [7:0]      ir_sh_r;
reg            byp_r;
reg [DR_W-1:0] dr_sh_r;
reg [7:0]      ir_r;
reg [DR_W-1:0] dr_hold_r;
reg            tdo_r;
reg            tdo_oe_r;

reg [15:0]     state_nxt;
reg [7:0]      ir_sh_nxt;
reg            byp_nxt;
reg [DR_W-1:0] dr_sh_nxt;
reg [7:0]      ir_nxt;
reg [DR_W-1:0] dr_hold_nxt;
reg            tdo_nxt;
reg            tdo_oe_nxt;

wire bypass_sel = (ir_r == `TBSQ_IR_BYPASS);
wire shift_st   = in_state(state_r, `TBSQ_ST_SHDR) |
                  in_state(state_r, `TBSQ_ST_SHIR);

// ----------------------------------------
// Work done on rising TCK
// ----------------------------------------
// Mode select and serial input are taken only at a rising edge
always @* begin
   state_nxt = state_r;
   ir_sh_nxt = ir_sh_r;
   byp_nxt   = byp_r;
   dr_sh_nxt = dr_sh_r;
   if (tck_rise) begin
      state_nxt = next_state(state_r, tms);
      if (in_state(state_r, `TBSQ_ST_CAPIR)) begin
         ir_sh_nxt = `TBSQ_IR_CAPTURE;
      end else if (in_state(state_r, `TBSQ_ST_SHIR)) begin
         ir_sh_nxt = {tdi, ir_sh_r[7:1]};
      end
      if (in_state(state_r, `TBSQ_ST_CAPDR)) begin
         byp_nxt   = 1'h0;
         dr_sh_nxt = dr_hold_r;
      end else if (in_state(state_r, `TBSQ_ST_SHDR)) begin
         byp_nxt   = tdi;
         dr_sh_nxt = {tdi, dr_sh_r[DR_W-1:1]};
      end
   end
end

// ----------------------------------------
// Work done on falling TCK
// ----------------------------------------
// Updates and the serial output move only at a falling edge, so the
// far side always sees a settled bit at its next rising edge
always @* begin
   ir_nxt      = ir_r;
   dr_hold_nxt = dr_hold_r;
   tdo_nxt     = tdo_r;
   tdo_oe_nxt  = tdo_oe_r;
   if (tck_fall) begin
      if (in_state(state_r, `TBSQ_ST_RESET)) begin
         ir_nxt = `TBSQ_IR_RESET;
      end else if (in_state(state_r, `TBSQ_ST_UPDIR)) begin
         ir_nxt = ir_sh_r;
      end
      if (in_state(state_r, `TBSQ_ST_UPDDR) && !bypass_sel) begin
         dr_hold_nxt = dr_sh_r;
      end
      // Driven only in shift states, released elsewhere
      tdo_oe_nxt = shift_st;
      if (in_state(state_r, `TBSQ_ST_SHIR)) begin
         tdo_nxt = ir_sh_r[0];
      end else if (in_state(state_r, `TBSQ_ST_SHDR)) begin
         tdo_nxt = bypass_sel ? byp_r : dr_sh_r[0];
      end
   end
end

// ----------------------------------------
// Registers
// ----------------------------------------
always @(posedge REF_CLK or posedge RST) begin
   if (RST) begin
      state_r   <= `TBSQ_ST_RESET;
      ir_sh_r   <= 8'h00;
      byp_r     <= 1'h0;
      dr_sh_r   <= {DR_W{1'b0}};
      ir_r      <= `TBSQ_IR_RESET;
      dr_hold_r <= {DR_W{1'b0}};
      tdo_r     <= 1'h0;
      tdo_oe_r  <= 1'h0;
   end else begin
      state_r   <= state_nxt;
      ir_sh_r   <= ir_sh_nxt;
      byp_r     <= byp_nxt;
      dr_sh_r   <= dr_sh_nxt;
      ir_r      <= ir_nxt;
      dr_hold_r <= dr_hold_nxt;
      tdo_r     <= tdo_nxt;
      tdo_oe_r  <= tdo_oe_nxt;
   end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
assign TDO_O     = tdo_r;
assign TDO_OE    = tdo_oe_r;
assign IR_ACTIVE = ir_r;
assign DR_HOLD   = dr_hold_r;
assign IN_RESET  = in_state(state_r, `TBSQ_ST_RESET);

endmodule

// ---- tbsq_defines.vh ----
// Constants for the test access port block
`ifndef TBSQ_DEFINES_VH
`define TBSQ_DEFINES_VH
// Controller states, one-hot
`define TBSQ_ST_RESET   16'h0001
`define TBSQ_ST_IDLE    16'h0002
`define TBSQ_ST_SELDR   16'h0004
`define TBSQ_ST_CAPDR   16'h0008
`define TBSQ_ST_SHDR    16'h0010
`define TBSQ_ST_EX1DR   16'h0020
`define TBSQ_ST_PAUSDR  16'h0040
`define TBSQ_ST_EX2DR   16'h0080
`define TBSQ_ST_UPDDR   16'h0100
`define TBSQ_ST_SELIR   16'h0200
`define TBSQ_ST_CAPIR   16'h0400
`define TBSQ_ST_SHIR    16'h0800
`define TBSQ_ST_EX1IR   16'h1000
`define TBSQ_ST_PAUSIR  16'h2000
`define TBSQ_ST_EX2IR   16'h4000
`define TBSQ_ST_UPDIR   16'h8000
// Instruction register
`define TBSQ_IR_CAPTURE 8'h81
`define TBSQ_IR_BYPASS  8'hff
`define TBSQ_IR_RESET   8'hff
`endif

// ---- tbsq_chk.sv ----
// Port checker for the test access port block
`timescale 1ns/1ps
module tbsq_chk (
   input wire       REF_CLK,
   input wire       RST,
   input wire       TCK,
   input wire       TDO_O,
   input wire       TDO_OE,
   input wire [7:0] IR_ACTIVE,
   input wire       IN_RESET
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   a_oe_in_reset: assert property (IN_RESET |-> !TDO_OE)
      else $error("output driven in reset state");
   a_oe_rise_low: assert property ($rose(TDO_OE) |-> !TCK)
      else $error("output enabled outside clock low phase");
   a_oe_fall_low: assert property ($fell(TDO_OE) |-> !TCK)
      else $error("output released outside clock low phase");
   a_ir_load_low: assert property ($changed(IR_ACTIVE) |-> !TCK)
      else $error("instruction changed outside clock low phase");
   a_tdo_hold_high: assert property (TCK && $past(TCK) |-> $stable(TDO_O))
      else $error("serial out moved while clock high");
   a_tdo_quiet_off: assert property ($changed(TDO_O) |-> TDO_OE)
      else $error("serial out moved while released");
endmodule
bind tbsq_tap tbsq_chk chk (.REF_CLK(REF_CLK), .RST(RST), .TCK(TCK),
   .TDO_O(TDO_O), .TDO_OE(TDO_OE), .IR_ACTIVE(IR_ACTIVE), .IN_RESET(IN_RESET));

// ---- tbsq_ctl.sv ----
// Test controller model that drives the test pins
`timescale 1ns/1ps
module tbsq_ctl (
   input  wire clk,
   output reg  TCK = 1'b1,
   output reg  TMS = 1'b1,
   output reg  TDI = 1'b1
);
   // One test clock cycle of 200 ns: low 4 clocks, high 4 clocks
   task step(input ms, input di);
      begin
         @(negedge clk);
         TCK = 1'b0;
         TMS = ms;
         TDI = di;
         repeat (4) @(negedge clk);
         TCK = 1'b1;
         repeat (3) @(negedge clk);
      end
   endtask
endmodule

// ---- tbsq_tap_test.sv ----
// Self-checking bench for the test access port block
`timescale 1ns/1ps
module tbsq_tap_test;
   reg        clk = 1'b0;
   reg        rst = 1'b1;
   wire       tck, tms, tdi, o, oe, in_rst;
   wire [7:0] ir, dr;
   integer    fail_count = 0;
   integer    check_count = 0;
   always #12.5 clk = ~clk;
   tbsq_tap uut (.REF_CLK(clk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi),
      .TDO_O(o), .TDO_OE(oe), .IR_ACTIVE(ir), .DR_HOLD(dr), .IN_RESET(in_rst));
   tbsq_ctl ctl (.clk(clk), .TCK(tck), .TMS(tms), .TDI(tdi));
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // Scan in bypass, scan 101 through it, return to reset
   task t_bypass_scan;
      reg [0:23] ms, ve, vd;
      integer i;
      begin
         ms = 24'b011000000000111000011111;
         ve = 24'b000001111111100001110000;
         vd = 24'b000001000000100000100000;
         chk(in_rst, 1'b1);
         for (i = 0; i < 24; i = i + 1) begin
            ctl.step(ms[i], i != 18);
            chk(oe, ve[i]);
            if (ve[i]) chk(o, vd[i]);
            if (i == 5) chk(in_rst, 1'b0);
            if (i == 15) chk(ir, 8'hff);
         end
         repeat (6) @(negedge clk);
         chk(in_rst, 1'b1);
         chk(dr, 8'h00);
         $display("t_bypass_scan done");
      end
   endtask
   // Load instruction 00, scan a5 into the user register, reset again
   task t_user_scan;
      reg [0:29] ms;
      reg [7:0]  d;
      integer i;
      begin
         ms = 30'b011000000000111000000000111111;
         d = 8'ha5;
         for (i = 0; i < 30; i = i + 1) begin
            ctl.step(ms[i], (i > 16 && i < 25) ? d[i-17] : 1'b0);
            chk(oe, (i > 4 && i < 13) || (i > 16 && i < 25));
            if (i > 4 && i < 13) chk(o, i == 5 || i == 12);
            if (i > 16 && i < 25) chk(o, 1'b0);
            if (i == 14) chk(ir, 8'h00);
            if (i == 26) chk(dr, 8'ha5);
         end
         chk(in_rst, 1'b1);
         chk(ir, 8'hff);
         $display("t_user_scan done");
      end
   endtask
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_bypass_scan;
      t_user_scan;
      stop_test;
   end
   initial begin
      #100000;
      fail_count = fail_count + 1;
      stop_test;
   end
endmodule
